/* inc/pcf_consts.vh */
// Offsets, field positions, reset values and bus codes of the configuration forwarder.
`ifndef PCF_CONSTS_VH
`define PCF_CONSTS_VH

// Register offsets inside the primary register image.
`define PCF_OFS_SETUP 12'h144
`define PCF_OFS_PAYLOAD 12'h148
`define PCF_OFS_INTACK 12'h14C

// Reset values.
`define PCF_RST_SETUP 32'h00000000
`define PCF_RST_PAYLOAD 32'h00000000
`define PCF_RST_INTACK 32'h00000000

// Setup register field positions.
`define PCF_BUS_HI 23
`define PCF_BUS_LO 16
`define PCF_SLOT_HI 15
`define PCF_SLOT_LO 11
`define PCF_FUNC_HI 10
`define PCF_FUNC_LO 8
`define PCF_DWORD_HI 7
`define PCF_DWORD_LO 2
`define PCF_TYPE_BIT 0

// Writable bits of the setup register; reserved bits read as zero.
`define PCF_SETUP_WMASK 32'h00FFFFFD

// Type 0 slot decode limits.
`define PCF_SLOT_UPPER_MAX 5'h0F
`define PCF_SLOT_LOWER_MAX 5'h14

// Secondary bus command codes.
`define PCF_CMD_INTACK 4'h0
`define PCF_CMD_CFG_RD 4'hA
`define PCF_CMD_CFG_WR 4'hB

// Synchroniser depth for inputs from outside the clock's domain.
`define PCF_SYNC_STAGES 2

`endif

/* core/pcf_sync.v */
// Two-flop synchroniser for a group of inputs from outside the ref_clk domain.
`timescale 1ns/10ps
module pcf_sync #(
  parameter WIDTH = 1
) (
  input wire ref_clk, // System clock.
  input wire rst_b, // Asynchronous reset, active low.
  input wire [WIDTH-1:0] asyncIn, // Input from another domain.
  output reg [WIDTH-1:0] syncOut // Input after two flops.
);

  reg [WIDTH-1:0] meta_reg;

  // The first stage is read only by the second stage.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end

endmodule

/* core/pcf_cfg_forwarder.v */
// Primary-to-secondary configuration and interrupt acknowledge cycle forwarder.
`timescale 1ns/10ps
`include "pcf_consts.vh"

module pcf_cfg_forwarder #(
  parameter DUAL_BUS = 1
) (
  input wire ref_clk, // System clock, 100 MHz.
  input wire rst_b, // Primary bus reset, active low.
  input wire p1Req, // Primary register request, one cycle.
  input wire p1Write, // Primary request is a write.
  input wire [31:0] p1Addr, // Primary access address.
  input wire [31:0] p1Wdata, // Primary write data.
  input wire [3:0] primaryByteEnables_b, // Primary byte enables, active low.
  output reg p1Ack, // Primary request completed, one cycle.
  output reg p1Retry, // Primary request must be retried, one cycle.
  output reg [31:0] p1Rdata, // Primary read data, valid with p1Ack.
  input wire opReq, // Secondary or processor port request, one cycle.
  input wire opWrite, // Other-port request is a write.
  input wire [11:0] opAddr, // Other-port register offset.
  input wire [31:0] opWdata, // Other-port write data.
  output reg opAck, // Other-port request completed, one cycle.
  output reg [31:0] opRdata, // Other-port read data.
  input wire secLinkClk, // Secondary bus clock.
  input wire secTargetDone, // Secondary target finished the cycle, level.
  input wire [31:0] secTargetData, // Secondary read data, valid with done.
  output reg secCycleValid, // Secondary cycle requested, level.
  output reg [3:0] secCmd, // Secondary bus command.
  output reg [31:0] secondaryAdLines, // Secondary address phase value.
  output reg [3:0] secByteEnables_b, // Secondary byte enables, active low.
  output reg [31:0] secWdata, // Secondary write data.
  output reg secBusy // Forwarder has a cycle in flight.
);

  // Engine states, one-hot. IDLE waits for a launch and a link falling edge,
  // WAIT holds the cycle until the target reports done, DROP lowers valid on
  // the next link falling edge and RELEASE waits for done to go away again.
  localparam ST_IDLE = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_DROP = 4'b0100;
  localparam ST_RELEASE = 4'b1000;

  // Programmer-visible registers.
  reg [31:0] setup_reg;
  reg [31:0] payload_reg;
  reg [31:0] intackVector_reg;
  // Launch request handed from the primary port to the engine.
  reg launch_reg;
  reg [3:0] launchCmd_reg;
  reg [31:0] launchAddr_reg;
  reg [3:0] launchBe_reg;
  // Delayed read bookkeeping: one shared slot for both read kinds.
  reg pendRead_reg;
  reg pendIack_reg;
  reg resultReady_reg;
  // Engine state, link edge detector and the captured secondary result.
  reg [3:0] state_reg;
  reg linkPrev_reg;
  reg doneDly_reg;
  reg engComplete_reg;
  reg engRead_reg;
  reg [31:0] engRdata_reg;
  // Synchronised inputs and engine handshake terms.
  wire linkSync;
  wire doneSync;
  wire [31:0] dataSync;
  wire linkFall;
  wire engAccept;
  wire engIdle;
  wire busyNow;
  wire implOn;
  wire [11:0] p1Ofs;
  wire hitSetup;
  wire hitPayload;
  wire hitIntack;
  // Byte lane mask and the two candidate address phases.
  wire [31:0] beMask;
  wire [31:0] type0Addr;
  wire [31:0] cfgAddr;

  ////////////////////////////////////////////////////////////////////////////
  // Crossing from the secondary clock domain.

  // The link clock is only sampled, never used as a clock, so its period must
  // span several ref_clk cycles for every edge to be seen.
  pcf_sync #(.WIDTH(1)) uLinkSync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .asyncIn(secLinkClk),
    .syncOut(linkSync)
  );

  // Done is a level held until valid falls, so two flops cannot lose it.
  pcf_sync #(.WIDTH(1)) uDoneSync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .asyncIn(secTargetDone),
    .syncOut(doneSync)
  );

  // Data is sampled only a cycle after done is seen, so it has settled by then.
  pcf_sync #(.WIDTH(32)) uDataSync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .asyncIn(secTargetData),
    .syncOut(dataSync)
  );

  // Secondary outputs change on the falling link edge so they stand at the rising one.
  assign linkFall = linkPrev_reg & ~linkSync;
  assign engIdle = (state_reg == ST_IDLE);
  assign engAccept = engIdle & linkFall & launch_reg;
  // Busy covers a queued launch, a cycle on the link and a parked read result.
  assign busyNow = launch_reg | ~engIdle | pendRead_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and secondary address forming.

  // Only the low twelve address bits select a register; the image base is
  // decoded outside this block.
  assign implOn = (DUAL_BUS != 0);
  assign p1Ofs = p1Addr[11:0];
  assign hitSetup = implOn & (p1Ofs == `PCF_OFS_SETUP);
  assign hitPayload = implOn & (p1Ofs == `PCF_OFS_PAYLOAD);
  assign hitIntack = implOn & (p1Ofs == `PCF_OFS_INTACK);

  // Byte lanes enabled by the primary master; a low enable writes its lane.
  assign beMask = {{8{~primaryByteEnables_b[3]}}, {8{~primaryByteEnables_b[2]}},
                   {8{~primaryByteEnables_b[1]}}, {8{~primaryByteEnables_b[0]}}};

  // Type 0 slot select: one line for slots up to 20, none above.
  // Bit 0 of the result is address line 11, bit 20 is address line 31.
  function [20:0] slotSelect;
    input [4:0] slot;
    begin
      if (slot <= `PCF_SLOT_UPPER_MAX) begin
        slotSelect = 21'h000020 << slot;
      end else if (slot <= `PCF_SLOT_LOWER_MAX) begin
        slotSelect = 21'h000001 << (slot - 5'h10);
      end else begin
        slotSelect = 21'h000000;
      end
    end
  endfunction

  // Type 0 address phase: slot select, function, dword and two zero bits.
  assign type0Addr = {slotSelect(setup_reg[`PCF_SLOT_HI:`PCF_SLOT_LO]),
                      setup_reg[`PCF_FUNC_HI:`PCF_FUNC_LO],
                      setup_reg[`PCF_DWORD_HI:`PCF_DWORD_LO], 2'b00};
  // Type 1 sends the setup word as it stands, type bit included.
  assign cfgAddr = setup_reg[`PCF_TYPE_BIT] ? setup_reg : type0Addr;

  ////////////////////////////////////////////////////////////////////////////
  // Secondary cycle engine: four-phase handshake with the target logic.

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      linkPrev_reg <= 1'b0;
      doneDly_reg <= 1'b0;
      engComplete_reg <= 1'b0;
      engRead_reg <= 1'b0;
      engRdata_reg <= 32'h00000000;
      secCycleValid <= 1'b0;
      secCmd <= `PCF_CMD_INTACK;
      secondaryAdLines <= 32'h00000000;
      secByteEnables_b <= 4'hF;
      secWdata <= 32'h00000000;
      secBusy <= 1'b0;
    end else begin
      // Edge detector and done delay run every cycle.
      linkPrev_reg <= linkSync;
      doneDly_reg <= doneSync;
      engComplete_reg <= 1'b0;
      // The busy output is a registered copy of the internal busy term.
      secBusy <= busyNow;
      case (state_reg)
        ST_IDLE: begin
          // Command, address, enables and data are latched together so cycles never mix.
          if (engAccept) begin
            secCycleValid <= 1'b1;
            secCmd <= launchCmd_reg;
            secondaryAdLines <= launchAddr_reg;
            secByteEnables_b <= launchBe_reg;
            secWdata <= payload_reg;
            engRead_reg <= (launchCmd_reg != `PCF_CMD_CFG_WR);
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Done must be seen on two samples in a row before the data is taken.
          if (doneSync && doneDly_reg) begin
            engRdata_reg <= dataSync;
            state_reg <= ST_DROP;
          end
        end
        ST_DROP: begin
          // Valid drops on a link falling edge, like every other secondary change.
          if (linkFall) begin
            secCycleValid <= 1'b0;
            state_reg <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          // Waiting for done to fall keeps a stale done from ending the next cycle.
          if (!doneSync) begin
            engComplete_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          // An illegal code returns to idle and releases the link.
          state_reg <= ST_IDLE;
          secCycleValid <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Primary register port: setup, posted writes and delayed reads.

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_reg <= `PCF_RST_SETUP;
      payload_reg <= `PCF_RST_PAYLOAD;
      intackVector_reg <= `PCF_RST_INTACK;
      launch_reg <= 1'b0;
      launchCmd_reg <= `PCF_CMD_INTACK;
      launchAddr_reg <= 32'h00000000;
      launchBe_reg <= 4'hF;
      pendRead_reg <= 1'b0;
      pendIack_reg <= 1'b0;
      resultReady_reg <= 1'b0;
      p1Ack <= 1'b0;
      p1Retry <= 1'b0;
      p1Rdata <= 32'h00000000;
      opAck <= 1'b0;
      opRdata <= 32'h00000000;
    end else begin
      p1Ack <= 1'b0;
      p1Retry <= 1'b0;
      opAck <= 1'b0;
      // Answers are one-cycle pulses; the branches below raise at most one.
      // The launch flag is dropped as soon as the engine takes it over.
      if (engAccept) begin
        launch_reg <= 1'b0;
      end
      // A finished read parks its result until a read of the same kind returns.
      if (engComplete_reg && engRead_reg) begin
        resultReady_reg <= 1'b1;
        // Vector reads and payload reads land in different registers.
        if (pendIack_reg) begin
          intackVector_reg <= engRdata_reg;
        end else begin
          payload_reg <= engRdata_reg;
        end
      end
      // Every primary request is answered by exactly one ack or one retry.
      if (p1Req) begin
        p1Rdata <= 32'h00000000;
        // Setup accesses complete at once; reserved bits stay zero.
        if (hitSetup) begin
          p1Ack <= 1'b1;
          if (p1Write) begin
            setup_reg <= (setup_reg & ~(beMask & `PCF_SETUP_WMASK)) |
                         (p1Wdata & beMask & `PCF_SETUP_WMASK);
          end else begin
            p1Rdata <= setup_reg;
          end
        end else if (hitPayload && p1Write) begin
          // A write can only be posted once the engine is free.
          if (busyNow) begin
            p1Retry <= 1'b1;
          end else begin
            p1Ack <= 1'b1;
            // Lanes left disabled keep their old payload bytes.
            payload_reg <= (payload_reg & ~beMask) | (p1Wdata & beMask);
            launch_reg <= 1'b1;
            launchCmd_reg <= `PCF_CMD_CFG_WR;
            launchAddr_reg <= cfgAddr;
            launchBe_reg <= primaryByteEnables_b;
          end
        end else if (hitPayload || (hitIntack && !p1Write)) begin
          // Delayed reads: claim a parked result, refuse while busy, or start a cycle.
          // A master that never returns leaves the slot parked; there is no timeout.
          if (resultReady_reg && (pendIack_reg == hitIntack)) begin
            p1Ack <= 1'b1;
            p1Rdata <= hitIntack ? intackVector_reg : payload_reg;
            resultReady_reg <= 1'b0;
            pendRead_reg <= 1'b0;
          end else if (busyNow) begin
            p1Retry <= 1'b1;
          end else begin
            p1Retry <= 1'b1;
            pendRead_reg <= 1'b1;
            pendIack_reg <= hitIntack;
            launch_reg <= 1'b1;
            // The secondary cycle reuses the enables of the read that started it.
            launchBe_reg <= primaryByteEnables_b;
            if (hitIntack) begin
              launchCmd_reg <= `PCF_CMD_INTACK;
              launchAddr_reg <= p1Addr;
            end else begin
              launchCmd_reg <= `PCF_CMD_CFG_RD;
              launchAddr_reg <= cfgAddr;
            end
          end
        end else begin
          // Vector writes, unmapped and absent registers complete with no effect.
          p1Ack <= 1'b1;
        end
      end
      // Secondary and processor ports never start a forwarded cycle.
      if (opReq) begin
        opAck <= 1'b1;
        opRdata <= 32'h00000000;
        // A primary setup write wins over an other-port setup write in one cycle.
        if (implOn && (opAddr == `PCF_OFS_SETUP)) begin
          if (opWrite && !(p1Req && hitSetup && p1Write)) begin
            setup_reg <= opWdata & `PCF_SETUP_WMASK;
          end else if (!opWrite) begin
            opRdata <= setup_reg;
          end
        end else if (implOn && (opAddr == `PCF_OFS_PAYLOAD) && !opWrite) begin
          opRdata <= payload_reg;
        end else begin
          opRdata <= 32'h00000000;
        end
      end
    end
  end

endmodule

/* sim/pcf_monitor.sv */
// Port checks for the configuration and acknowledge forwarder.
`timescale 1ns/10ps
module pcf_monitor (
  input wire ref_clk, // Clock.
  input wire rst_b, // Reset, active low.
  input wire p1Req, // Primary request.
  input wire p1Write, // Primary write.
  input wire [31:0] p1Addr, // Primary address.
  input wire p1Ack, // Primary ack.
  input wire p1Retry, // Primary retry.
  input wire opReq, // Other-port request.
  input wire opWrite, // Other-port write.
  input wire [11:0] opAddr, // Other-port offset.
  input wire opAck, // Other-port ack.
  input wire [31:0] opRdata, // Other-port data.
  input wire secTargetDone, // Target done.
  input wire secCycleValid, // Cycle requested.
  input wire [3:0] secCmd, // Bus command.
  input wire [31:0] secondaryAdLines, // Address phase.
  input wire secBusy // Cycle in flight.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // Request answers come exactly one cycle after the taking edge.
  a_p1_one_answer: assert property (p1Req |=> p1Ack ^ p1Retry)
    else $error("primary request answer wrong");
  a_p1_no_answer: assert property (!p1Req |=> !p1Ack && !p1Retry)
    else $error("primary answer without request");
  a_op_answer: assert property (opReq |=> opAck)
    else $error("other-port request not acked");
  // Other ports see a zero vector and never start a cycle.
  a_op_vec_zero: assert property (opReq && !opWrite && opAddr == 12'h14C
    |=> opRdata == 32'h0)
    else $error("other-port vector read not zero");
  // A primary request one cycle earlier may legally raise busy, so it is excluded.
  a_op_no_cycle: assert property (opReq && !p1Req && !$past(p1Req) && !secBusy
    |=> !secBusy)
    else $error("other-port request started a cycle");
  // A type zero address has at most one select line and low bits 00.
  a_type0_addr: assert property (secCycleValid && secCmd != 4'h0
    && !secondaryAdLines[0]
    |-> $countones(secondaryAdLines[31:11]) <= 1 && secondaryAdLines[1:0] == 2'b00)
    else $error("type zero address malformed");
  a_valid_hold: assert property (secCycleValid && !secTargetDone
    |=> secCycleValid && $stable(secondaryAdLines))
    else $error("secondary cycle dropped early");
  a_valid_drop: assert property (secCycleValid && secTargetDone |-> ##[1:60] !secCycleValid)
    else $error("secondary cycle not ended");
  // A second read or a write while busy is refused, not queued.
  a_inflight_retry: assert property (p1Req && !p1Write && p1Addr[11:0] == 12'h14C
    && secCycleValid |=> p1Retry)
    else $error("repeat read not retried");
  // Busy lags the engine by a cycle; a cycle on the link is busy for certain.
  a_busy_wr_retry: assert property (p1Req && p1Write && p1Addr[11:0] == 12'h148
    && secCycleValid |=> p1Retry)
    else $error("write while busy not retried");
  c_retry: cover property (p1Req ##1 p1Retry);
  c_intack: cover property (secCycleValid && secCmd == 4'h0);
  c_done: cover property (secTargetDone ##1 !secCycleValid);
endmodule

/* sim/pcf_sec_target.sv */
// Secondary bus target model with its free-running bus clock.
`timescale 1ns/10ps
module pcf_sec_target (
  input wire ref_clk, // System clock.
  input wire secCycleValid, // Cycle requested.
  input wire [31:0] vecVal, // Data to return.
  input wire [7:0] lat, // Answer delay in clocks.
  output reg secLinkClk, // Secondary bus clock.
  output reg secTargetDone, // Cycle done, level.
  output reg [31:0] secTargetData // Read data.
);
  reg [7:0] waitCnt;
  // The bus clock runs free, offset in phase from ref_clk.
  initial begin
    secLinkClk = 1'b0;
    secTargetDone = 1'b0;
    secTargetData = 32'h0;
    waitCnt = 8'h0;
    #3.3;
    forever #62.5 secLinkClk = ~secLinkClk;
  end
  // Four-phase answer; data flips once released so a stale word never matches.
  always @(posedge ref_clk) begin
    if (secCycleValid && !secTargetDone) begin
      waitCnt <= waitCnt + 8'h1;
      if (waitCnt >= lat) begin
        secTargetDone <= 1'b1;
        secTargetData <= vecVal;
        waitCnt <= 8'h0;
      end
    end else if (!secCycleValid && secTargetDone) begin
      secTargetDone <= 1'b0;
      secTargetData <= ~secTargetData;
    end
  end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the configuration and acknowledge forwarder.
`timescale 1ns/10ps
`include "pcf_consts.vh"
module testbench;
  reg ref_clk, rst_b, p1Req, p1Write, opReq, opWrite, ack, rty;
  reg [31:0] p1Addr, p1Wdata, opWdata, vecVal, rd;
  reg [11:0] opAddr;
  reg [3:0] primaryByteEnables_b;
  reg [7:0] lat;
  wire p1Ack, p1Retry, opAck, secLinkClk, secTargetDone, secCycleValid, secBusy, sAck;
  wire [31:0] p1Rdata, opRdata, secTargetData, secondaryAdLines, secWdata, sRdata;
  wire [3:0] secCmd, secByteEnables_b;
  integer error_cnt, cmp_count, i, j;
  pcf_cfg_forwarder #(.DUAL_BUS(1)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .p1Req(p1Req),
    .p1Write(p1Write), .p1Addr(p1Addr), .p1Wdata(p1Wdata),
    .primaryByteEnables_b(primaryByteEnables_b), .p1Ack(p1Ack), .p1Retry(p1Retry),
    .p1Rdata(p1Rdata), .opReq(opReq), .opWrite(opWrite), .opAddr(opAddr), .opWdata(opWdata),
    .opAck(opAck), .opRdata(opRdata), .secLinkClk(secLinkClk), .secTargetDone(secTargetDone),
    .secTargetData(secTargetData), .secCycleValid(secCycleValid), .secCmd(secCmd),
    .secondaryAdLines(secondaryAdLines), .secByteEnables_b(secByteEnables_b),
    .secWdata(secWdata), .secBusy(secBusy));
  pcf_sec_target i_tgt (.ref_clk(ref_clk), .secCycleValid(secCycleValid), .vecVal(vecVal),
    .lat(lat), .secLinkClk(secLinkClk), .secTargetDone(secTargetDone),
    .secTargetData(secTargetData));
  // Single-bus variant: same primary traffic, no forwarded registers.
  pcf_cfg_forwarder #(.DUAL_BUS(0)) i_dutSingle (.ref_clk(ref_clk), .rst_b(rst_b),
    .p1Req(p1Req), .p1Write(p1Write), .p1Addr(p1Addr), .p1Wdata(p1Wdata),
    .primaryByteEnables_b(primaryByteEnables_b), .p1Ack(sAck), .p1Retry(), .p1Rdata(sRdata),
    .opReq(opReq), .opWrite(opWrite), .opAddr(opAddr), .opWdata(opWdata), .opAck(),
    .opRdata(), .secLinkClk(secLinkClk), .secTargetDone(secTargetDone),
    .secTargetData(secTargetData), .secCycleValid(), .secCmd(), .secondaryAdLines(),
    .secByteEnables_b(), .secWdata(), .secBusy());
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, count and report.
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One primary request; the answer stands for one cycle after the taking edge.
  task p1(input wr, input [31:0] a, input [31:0] d, input [3:0] be);
    begin
      @(posedge ref_clk);
      p1Req <= 1'b1;
      p1Write <= wr;
      p1Addr <= a;
      p1Wdata <= d;
      primaryByteEnables_b <= be;
      @(posedge ref_clk);
      p1Req <= 1'b0;
      #1;
      ack = p1Ack;
      rty = p1Retry;
      rd = p1Rdata;
    end
  endtask
  // One other-port request; the ack stands for one cycle after the taking edge.
  task op(input wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      opReq <= 1'b1;
      opWrite <= wr;
      opAddr <= a;
      opWdata <= d;
      @(posedge ref_clk);
      opReq <= 1'b0;
      #1;
      chk(opAck, 1'b1);
      rd = opRdata;
    end
  endtask
  // Wait for the secondary cycle and judge its address phase.
  task secChk(input [3:0] cmd, input [31:0] ad, input [3:0] be);
    begin
      for (i = 0; i < 400 && secCycleValid !== 1'b1; i = i + 1) @(posedge ref_clk);
      #1;
      chk(secCmd, cmd);
      chk(secondaryAdLines, ad);
      chk(secByteEnables_b, be);
    end
  endtask
  // Keep retrying a delayed read until it completes, then judge the data.
  task rdClaim(input [31:0] a, input [3:0] be, input [31:0] exp);
    begin
      ack = 1'b0;
      for (i = 0; i < 300 && ack !== 1'b1; i = i + 1) p1(1'b0, a, 32'h0, be);
      chk(rd, exp);
    end
  endtask
  function [31:0] t0Addr(input [4:0] s, input [2:0] f, input [5:0] r);
    t0Addr = (s < 5'h10 ? 32'h1 << (16 + s) : s < 5'h15 ? 32'h1 << (s - 5) : 32'h0)
      | {21'h0, f, r, 2'b00};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped offset and the zero vector seen by other ports.
  task tReset;
    begin
      op(1'b0, `PCF_OFS_SETUP, 32'h0);
      chk(rd, `PCF_RST_SETUP);
      op(1'b0, `PCF_OFS_INTACK, 32'h0);
      chk(rd, 32'h0);
      p1(1'b0, 32'h144, 32'h0, 4'h0);
      chk(ack, 1'b1);
      chk(rd, `PCF_RST_SETUP);
      p1(1'b0, 32'h150, 32'h0, 4'h0);
      chk(ack, 1'b1);
      chk(rd, 32'h0);
      p1(1'b1, 32'h144, 32'hFFFFFFFF, 4'h0);
      p1(1'b0, 32'h144, 32'h0, 4'h0);
      chk(rd, `PCF_SETUP_WMASK);
      chk(sAck, 1'b1);
      chk(sRdata, 32'h0);
      $display("test reset done");
    end
  endtask
  // Type zero writes at slots 0 to 30 in steps of five; a second write while busy is refused.
  task tType0;
    begin
      for (j = 0; j < 32; j = j + 5) begin
        p1(1'b1, 32'h144, {8'h0, 8'h5A, j[4:0], 3'h5, 6'h2B, 2'b00}, 4'h0);
        p1(1'b0, 32'h144, 32'h0, 4'h0);
        chk(rd, {8'h0, 8'h5A, j[4:0], 3'h5, 6'h2B, 2'b00});
        p1(1'b1, 32'h148, 32'hA500 + j, 4'h0);
        chk(ack, 1'b1);
        p1(1'b1, 32'h148, 32'h0, 4'h0);
        chk(rty, 1'b1);
        chk(secBusy, 1'b1);
        secChk(4'hB, t0Addr(j[4:0], 3'h5, 6'h2B), 4'h0);
        chk(secWdata, 32'hA500 + j);
        p1(1'b1, 32'h148, 32'h0, 4'h0);
        chk(rty, 1'b1);
        for (i = 0; i < 400 && secBusy !== 1'b0; i = i + 1) @(posedge ref_clk);
        chk(secBusy, 1'b0);
      end
      $display("test type zero done");
    end
  endtask
  // Type one delayed read with a slow target and a repeat read meanwhile.
  task tType1;
    begin
      lat <= 8'h28;
      vecVal <= 32'h1357BEEF;
      p1(1'b1, 32'h144, 32'hFFC35A6F, 4'h0);
      p1(1'b0, 32'h148, 32'h0, 4'h0);
      chk(rty, 1'b1);
      secChk(4'hA, 32'h00C35A6D, 4'h0);
      p1(1'b0, 32'h148, 32'h0, 4'h0);
      chk(rty, 1'b1);
      rdClaim(32'h148, 4'h0, 32'h1357BEEF);
      $display("test type one done");
    end
  endtask
  // Acknowledge cycle with prompt target; other-port accesses meanwhile.
  task tIntack;
    begin
      lat <= 8'h1;
      vecVal <= 32'hC0DE5A17;
      p1(1'b0, 32'h8765414C, 32'h0, 4'h6);
      chk(rty, 1'b1);
      op(1'b1, `PCF_OFS_PAYLOAD, 32'h0BAD0BAD);
      op(1'b0, `PCF_OFS_INTACK, 32'h0);
      chk(rd, 32'h0);
      secChk(4'h0, 32'h8765414C, 4'h6);
      rdClaim(32'h8765414C, 4'h6, 32'hC0DE5A17);
      op(1'b0, `PCF_OFS_PAYLOAD, 32'h0);
      chk(rd, 32'h1357BEEF);
      $display("test intack done");
    end
  endtask
  task results;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, reset and the main sequence.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    {rst_b, p1Req, p1Write, opReq, opWrite, ack, rty} = 7'h0;
    {p1Addr, p1Wdata, opWdata, vecVal, rd} = 160'h0;
    opAddr = 12'h0;
    primaryByteEnables_b = 4'hF;
    lat = 8'h1;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    tReset;
    tType0;
    tType1;
    tIntack;
    results;
  end
  // Watchdog: far beyond the few hundred cycles the tests need.
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt = error_cnt + 1;
    results;
  end
endmodule
bind pcf_cfg_forwarder pcf_monitor i_mon (.ref_clk(ref_clk), .rst_b(rst_b), .p1Req(p1Req),
  .p1Write(p1Write), .p1Addr(p1Addr), .p1Ack(p1Ack), .p1Retry(p1Retry), .opReq(opReq),
  .opWrite(opWrite), .opAddr(opAddr), .opAck(opAck), .opRdata(opRdata),
  .secTargetDone(secTargetDone), .secCycleValid(secCycleValid), .secCmd(secCmd),
  .secondaryAdLines(secondaryAdLines), .secBusy(secBusy));
